// ===== core_model.sv
// Core and peripheral request model facing the interrupt front end
`timescale 1ns/100ps
module core_model
    import ext_irq_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic auto_i,
    input wire logic [3:0] ack_wait_i,
    input wire logic [7:0] svc_len_i,
    input wire logic [2:0] raise_i,
    input wire logic req_i,
    input wire logic high_i,
    input wire logic [2:0] vec_i,
    output logic ack_o,
    output logic ret_o,
    output logic [2:0] lvl_req_o
);
    logic [5:0] log_q [$]; // Depth, level, source per accepted request
    logic [3:0] wait_cnt; // Cycles the shown request has waited
    logic [7:0] tmr [4]; // Service time left per nesting depth
    logic [1:0] depth; // Services now open
    // One ack pulse per request, never two in a row; returns pop the nest
    always @(posedge clock_i)
    begin
        ack_o <= 1'b0;
        ret_o <= 1'b0;
        lvl_req_o <= lvl_req_o | raise_i;
        if (sys_rst_i)
        begin
            lvl_req_o <= 3'h0;
            wait_cnt <= 4'h0;
            depth <= 2'h0;
        end
        else if (ack_o)
        begin
            // Owner drops its level request once vectored
            if (vec_i >= SRC_SER && vec_i <= SRC_BT)
                lvl_req_o[vec_i - SRC_SER] <= 1'b0;
            log_q.push_back({depth, high_i, vec_i});
            tmr[depth] <= svc_len_i;
            depth <= depth + 2'h1;
        end
        // Slow answer: let the request stand a while
        else if (auto_i && req_i && wait_cnt < ack_wait_i)
            wait_cnt <= wait_cnt + 4'h1;
        else if (auto_i && req_i)
        begin
            ack_o <= 1'b1;
            wait_cnt <= 4'h0;
        end
        // Innermost service ends first
        else if (depth != 2'h0 && tmr[depth - 2'h1] == 8'h00)
        begin
            ret_o <= 1'b1;
            depth <= depth - 2'h1;
        end
        else if (depth != 2'h0)
            tmr[depth - 2'h1] <= tmr[depth - 2'h1] - 8'h01;
    end
endmodule

// ===== ext_irq_edge_priority.sv
// Edge-selectable external interrupts with two-level priority arbitration
`timescale 1ns/100ps
module ext_irq_edge_priority
    import ext_irq_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ext_pins_t ext_pins_i,
    input wire logic [1:0] group_ab_priority_i,
    input wire logic serial_if_b_req_i,
    input wire logic pulse_width_irq_req_i,
    input wire logic base_timer_req_i,
    input wire logic core_ack_i,
    input wire logic core_ret_i,
    output logic core_req_o,
    output logic [2:0] core_vector_o,
    output logic core_high_o,
    output logic irq_o
);

    // Index decode needs bits 9:2 plus at least one bit above for the range check
    if (ADDR_W < 11)
    begin : g_bad_width
        $error("ADDR_W too small for the register map");
    end

    // Lowest set bit wins: fixed query order
    function automatic logic [2:0] pick(input logic [NUM_SRC-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Software registers
    logic [7:0] trc; // Timer storage plus group flags
    logic [3:0] prio; // Second priority bank
    logic [A_PINS-1:0] a_fall_en;
    logic [A_PINS-1:0] a_rise_en;
    logic [B_PINS-1:0] b_fall_en;
    logic [B_PINS-1:0] b_rise_en;
    logic [C_PINS-1:0] c_fall_en;
    logic [C_PINS-1:0] c_rise_en;
    logic [7:0] ctrl; // Global and per-source enables
    logic [2:0] stat; // Sticky edge events
    logic [2:0] mask; // Interrupt mask
    logic c_flag; // Group C pending flag
    service_t svc; // Levels in service
    service_t next_svc;

    // Bus decode
    logic bus_req;
    logic bus_wr;
    logic [7:0] idx;
    logic in_range;
    logic [7:0] wdat;
    logic [7:0] rdat;
    assign bus_req = wb_cyc_i & wb_stb_i;
    // Write commits on the edge where ack is seen high
    assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign in_range = (wb_adr_i[ADDR_W-1:10] == '0);
    assign wdat = wb_dat_i[7:0];

    // Helper for register write strobes
    function automatic logic wr_hit(input logic [7:0] at);
        return bus_wr && in_range && idx == at;
    endfunction

    // Pin synchronisers; stage one feeds only stage two
    ext_pins_t sync1;
    ext_pins_t sync2;
    ext_pins_t prev;
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end
        else
        begin
            sync1 <= ext_pins_i;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Edge detect on the settled copies
    ext_pins_t rise;
    ext_pins_t fall;
    assign rise = sync2 & ~prev;
    assign fall = ~sync2 & prev;

    // Group events: enabled edges ORed per group
    logic ev_a;
    logic ev_b;
    logic ev_c;
    assign ev_a = |((rise.a & a_rise_en) | (fall.a & a_fall_en));
    assign ev_b = |((rise.b & b_rise_en) | (fall.b & b_fall_en));
    assign ev_c = |((rise.c & c_rise_en) | (fall.c & c_fall_en));

    // Core acknowledge accepted only against a shown request
    logic taken;
    assign taken = core_ack_i & core_req_o;

    // Arbitration vectors in query order
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] prio_vec;
    logic [NUM_SRC-1:0] elig;
    logic [NUM_SRC-1:0] elig_high;
    logic [NUM_SRC-1:0] elig_low;
    assign pend = {c_flag, base_timer_req_i, pulse_width_irq_req_i,
                   serial_if_b_req_i, trc[TRC_B_FLAG], trc[TRC_A_FLAG]};
    assign prio_vec = {prio[PRIO_C], prio[PRIO_BT], prio[PRIO_PWM],
                       prio[PRIO_SER], group_ab_priority_i};
    // Global enable gates every source of the core request; irq_o is not gated
    assign elig = ctrl[CTRL_GLOBAL] ? (pend & ctrl[NUM_SRC-1:0]) : '0;
    assign elig_high = elig & prio_vec;
    assign elig_low = elig & ~prio_vec;

    // Bus slave: ack one cycle after request, dropped after one
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= {24'h000000, rdat};
        end
    end

    // Read mux; unmapped indices read zero
    always_comb
    begin
        rdat = 8'h00;
        if (in_range)
        begin
            case (idx)
                IDX_TRC: rdat = trc;
                IDX_PRIO: rdat = {4'h0, prio};
                IDX_A_FALL: rdat = {4'h0, a_fall_en};
                IDX_A_RISE: rdat = {4'h0, a_rise_en};
                IDX_B_FALL: rdat = {4'h0, b_fall_en};
                IDX_B_RISE: rdat = {4'h0, b_rise_en};
                IDX_C_FALL: rdat = {2'h0, c_fall_en};
                IDX_C_RISE: rdat = {2'h0, c_rise_en};
                IDX_CTRL: rdat = ctrl;
                IDX_STAT: rdat = {5'h00, stat};
                IDX_MASK: rdat = {5'h00, mask};
                IDX_SERV: rdat = {1'b0, core_vector_o, c_flag, core_req_o, svc};
                default: rdat = 8'h00;
            endcase
        end
    end

    // Plain configuration registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            prio <= REG_RESET[3:0];
            a_fall_en <= REG_RESET[A_PINS-1:0];
            a_rise_en <= REG_RESET[A_PINS-1:0];
            b_fall_en <= REG_RESET[B_PINS-1:0];
            b_rise_en <= REG_RESET[B_PINS-1:0];
            c_fall_en <= REG_RESET[C_PINS-1:0];
            c_rise_en <= REG_RESET[C_PINS-1:0];
            ctrl <= REG_RESET;
            mask <= REG_RESET[2:0];
        end
        else
        begin
            if (wr_hit(IDX_PRIO)) prio <= wdat[3:0];
            if (wr_hit(IDX_A_FALL)) a_fall_en <= wdat[A_PINS-1:0];
            if (wr_hit(IDX_A_RISE)) a_rise_en <= wdat[A_PINS-1:0];
            if (wr_hit(IDX_B_FALL)) b_fall_en <= wdat[B_PINS-1:0];
            if (wr_hit(IDX_B_RISE)) b_rise_en <= wdat[B_PINS-1:0];
            if (wr_hit(IDX_C_FALL)) c_fall_en <= wdat[C_PINS-1:0];
            if (wr_hit(IDX_C_RISE)) c_rise_en <= wdat[C_PINS-1:0];
            if (wr_hit(IDX_CTRL)) ctrl <= wdat;
            if (wr_hit(IDX_MASK)) mask <= wdat[2:0];
        end
    end

    // Group request flags: event set beats any clear
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            trc <= REG_RESET;
            c_flag <= 1'b0;
        end
        else
        begin
            // Timer bits are only stored here
            if (wr_hit(IDX_TRC))
            begin
                trc[7:4] <= wdat[7:4] & TRC_STORE_MASK[7:4];
            end
            // Group A flag
            if (ev_a)
            begin
                trc[TRC_A_FLAG] <= 1'b1;
            end
            else if (wr_hit(IDX_TRC))
            begin
                trc[TRC_A_FLAG] <= wdat[TRC_A_FLAG];
            end
            else if (taken && core_vector_o == SRC_A)
            begin
                trc[TRC_A_FLAG] <= 1'b0;
            end
            // Group B flag
            if (ev_b)
            begin
                trc[TRC_B_FLAG] <= 1'b1;
            end
            else if (wr_hit(IDX_TRC))
            begin
                trc[TRC_B_FLAG] <= wdat[TRC_B_FLAG];
            end
            else if (taken && core_vector_o == SRC_B)
            begin
                trc[TRC_B_FLAG] <= 1'b0;
            end
            // Group C flag has no software view to write
            if (ev_c)
            begin
                c_flag <= 1'b1;
            end
            else if (taken && core_vector_o == SRC_C)
            begin
                c_flag <= 1'b0;
            end
        end
    end

    // Sticky edge status, write one to clear, set wins
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            stat <= REG_RESET[2:0];
        end
        else
        begin
            stat <= (stat & ~(wr_hit(IDX_STAT) ? wdat[2:0] : 3'h0))
                    | {ev_c, ev_b, ev_a};
        end
    end

    // Interrupt line registered from status and mask
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(stat & mask);
        end
    end

    // Service level tracking: push on response, pop on return
    always_comb
    begin
        next_svc = svc;
        case (svc)
            SERV_IDLE:
            begin
                if (taken)
                begin
                    next_svc = core_high_o ? SERV_HIGH : SERV_LOW;
                end
            end
            SERV_LOW:
            begin
                if (taken)
                begin
                    next_svc = SERV_HOL;
                end
                else if (core_ret_i)
                begin
                    next_svc = SERV_IDLE;
                end
            end
            SERV_HOL:
            begin
                if (core_ret_i)
                begin
                    next_svc = SERV_LOW;
                end
            end
            SERV_HIGH:
            begin
                if (core_ret_i)
                begin
                    next_svc = SERV_IDLE;
                end
            end
            default: next_svc = SERV_IDLE;
        endcase
    end

    // Service level register
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            svc <= SERV_IDLE;
        end
        else
        begin
            svc <= next_svc;
        end
    end

    // Request to the core; dropped one cycle after a response
    // so the cleared flag is never offered twice
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            core_req_o <= 1'b0;
            core_vector_o <= SRC_A;
            core_high_o <= 1'b0;
        end
        else if (taken)
        begin
            core_req_o <= 1'b0;
        end
        else
        begin
            case (svc)
                SERV_IDLE:
                begin
                    // High first, then query order within a level
                    core_req_o <= |elig;
                    core_high_o <= |elig_high;
                    core_vector_o <= (|elig_high) ? pick(elig_high)
                                                  : pick(elig_low);
                end
                SERV_LOW:
                begin
                    core_req_o <= |elig_high;
                    core_high_o <= 1'b1;
                    core_vector_o <= pick(elig_high);
                end
                default:
                begin
                    // Nothing preempts high service
                    core_req_o <= 1'b0;
                end
            endcase
        end
    end

    // Helper: priority of each source one cycle back
    logic [NUM_SRC-1:0] prio_past;
    always_ff @(posedge clock_i)
    begin
        prio_past <= prio_vec;
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    property p_a_rise_flag;
        ($rose(ext_pins_i.a[0]) && a_rise_en[0] && $stable(a_rise_en))
            |-> ##[1:4] trc[TRC_A_FLAG];
    endproperty
    a_a_rise_flag: assert property (p_a_rise_flag)
        else $error("Group A rising edge lost");

    property p_a_no_fall;
        (fall.a != '0 && a_fall_en == '0 && a_rise_en == '0) |-> !ev_a;
    endproperty
    a_a_no_fall: assert property (p_a_no_fall)
        else $error("Disabled group A edge raised a request");

    property p_b_flag;
        ev_b |=> trc[TRC_B_FLAG];
    endproperty
    a_b_flag: assert property (p_b_flag)
        else $error("Group B flag missed its event");

    property p_c_flag;
        ev_c |=> c_flag;
    endproperty
    a_c_flag: assert property (p_c_flag)
        else $error("Group C flag missed its event");

    property p_a_clear;
        (taken && core_vector_o == SRC_A && !ev_a && !wr_hit(IDX_TRC))
            |=> !trc[TRC_A_FLAG];
    endproperty
    a_a_clear: assert property (p_a_clear)
        else $error("Group A flag not cleared on response");

    property p_one_event;
        rise.a[0] |=> !rise.a[0];
    endproperty
    a_one_event: assert property (p_one_event)
        else $error("One edge gave two events");

    property p_dual_edge;
        (a_rise_en[0] && a_fall_en[0] && (rise.a[0] || fall.a[0])) |-> ev_a;
    endproperty
    a_dual_edge: assert property (p_dual_edge)
        else $error("Dual edge pin gave no event");

    property p_no_preempt_high;
        (svc == SERV_HIGH || svc == SERV_HOL) |-> !core_req_o;
    endproperty
    a_no_preempt_high: assert property (p_no_preempt_high)
        else $error("Request during high service");

    property p_low_only_high;
        (core_req_o && svc == SERV_LOW) |-> core_high_o;
    endproperty
    a_low_only_high: assert property (p_low_only_high)
        else $error("Same level request preempted low service");

    property p_query_order;
        (svc == SERV_IDLE && elig_low[0] && elig_low[1] && elig_high == '0
            && !core_ack_i) |=> (core_req_o && core_vector_o == SRC_A);
    endproperty
    a_query_order: assert property (p_query_order)
        else $error("Larger query number served first");

    property p_global_off;
        !ctrl[CTRL_GLOBAL] |=> !core_req_o;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("Request with global enable off");

    property p_level_bits;
        core_req_o |-> core_high_o == prio_past[core_vector_o];
    endproperty
    a_level_bits: assert property (p_level_bits)
        else $error("Request level disagrees with priority bit");

    property p_cv_nested;
        svc == SERV_LOW ##1 svc == SERV_HOL;
    endproperty
    c_cv_nested: cover property (p_cv_nested);

    property p_cv_irq;
        $rose(irq_o);
    endproperty
    c_cv_irq: cover property (p_cv_irq);

    property p_cv_two_low;
        elig_low[0] && elig_low[1] && svc == SERV_IDLE;
    endproperty
    c_cv_two_low: cover property (p_cv_two_low);

endmodule

// ===== ext_irq_pkg.sv
// Constants and types shared by the external interrupt front end
package ext_irq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TRC = 8'h88;
    localparam logic [7:0] IDX_PRIO = 8'hb9;
    localparam logic [7:0] IDX_A_FALL = 8'hba;
    localparam logic [7:0] IDX_A_RISE = 8'hbb;
    localparam logic [7:0] IDX_B_FALL = 8'hbc;
    localparam logic [7:0] IDX_B_RISE = 8'hbd;
    localparam logic [7:0] IDX_C_FALL = 8'hc6;
    localparam logic [7:0] IDX_C_RISE = 8'hc7;
    localparam logic [7:0] IDX_CTRL = 8'hd0;
    localparam logic [7:0] IDX_STAT = 8'hd1;
    localparam logic [7:0] IDX_MASK = 8'hd2;
    localparam logic [7:0] IDX_SERV = 8'hd3;
    // Field positions
    localparam int TRC_B_FLAG = 3;
    localparam int TRC_A_FLAG = 1;
    localparam logic [7:0] TRC_STORE_MASK = 8'hf0;
    localparam int PRIO_C = 3;
    localparam int PRIO_BT = 2;
    localparam int PRIO_PWM = 1;
    localparam int PRIO_SER = 0;
    localparam int CTRL_GLOBAL = 7;
    // Source numbers, also the fixed query order
    localparam logic [2:0] SRC_A = 3'h0;
    localparam logic [2:0] SRC_B = 3'h1;
    localparam logic [2:0] SRC_SER = 3'h2;
    localparam logic [2:0] SRC_PWM = 3'h3;
    localparam logic [2:0] SRC_BT = 3'h4;
    localparam logic [2:0] SRC_C = 3'h5;
    localparam int NUM_SRC = 6;
    // Reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;
    // Pin group widths
    localparam int A_PINS = 4;
    localparam int B_PINS = 4;
    localparam int C_PINS = 6;
    // Service level, Gray coded along idle-low-nested-high
    typedef enum logic [1:0] {
        SERV_IDLE = 2'b00,
        SERV_LOW = 2'b01,
        SERV_HOL = 2'b11,
        SERV_HIGH = 2'b10
    } service_t;
    // External interrupt pins
    typedef struct packed {
        logic [C_PINS-1:0] c;
        logic [B_PINS-1:0] b;
        logic [A_PINS-1:0] a;
    } ext_pins_t;
endpackage

// ===== tb_top.sv
// Self-checking bench for the external interrupt front end
`timescale 1ns/100ps
module tb_top
    import ext_irq_pkg::*;
;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0, sel_v = 4'h1, ack_wait = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, ack, ret, req, high, irq;
    ext_pins_t pins = '0; // Pins idle low
    logic [1:0] ab_prio = 2'h0;
    logic [2:0] vec, lvl, raise = 3'h0;
    logic auto_en = 1'b0; // Partner answers on its own
    logic [7:0] svc_len = 8'h04, d;
    int num_errors = 0, cmp_count = 0;

    // System clock, 20 ns period
    always #10 clock_i = ~clock_i;

    ext_irq_edge_priority #(.ADDR_W(12)) DUT (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_pins_i(pins),
        .group_ab_priority_i(ab_prio), .serial_if_b_req_i(lvl[0]),
        .pulse_width_irq_req_i(lvl[1]), .base_timer_req_i(lvl[2]), .core_ack_i(ack),
        .core_ret_i(ret), .core_req_o(req), .core_vector_o(vec), .core_high_o(high),
        .irq_o(irq)
    );

    core_model core (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .auto_i(auto_en), .ack_wait_i(ack_wait),
        .svc_len_i(svc_len), .raise_i(raise), .req_i(req), .high_i(high), .vec_i(vec),
        .ack_o(ack), .ret_o(ret), .lvl_req_o(lvl)
    );

    // Verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Classic cycle held until ack is sampled; read data lands in d
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel_v;
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        d = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask

    // Pin change, then room for sync and flag
    task automatic pin(input int b, input logic v);
        @(posedge clock_i);
        pins[b] <= v;
        cyc(6);
    endtask

    // One-cycle pulse on the peripheral level requests
    task automatic kick(input logic [2:0] v);
        @(posedge clock_i);
        raise <= v;
        @(posedge clock_i);
        raise <= 3'h0;
    endtask

    task automatic wait_log(input int n);
        int k;
        k = 0;
        while (core.log_q.size() < n && k < 600)
        begin
            @(posedge clock_i);
            k++;
        end
        if (core.log_q.size() < n)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask

    // Reset values, writable bits, ignored lane, unmapped index
    task automatic t_regs();
        logic [7:0] idx [8];
        logic [7:0] msk [8];
        idx = '{IDX_TRC, IDX_PRIO, IDX_A_FALL, IDX_A_RISE, IDX_B_FALL, IDX_B_RISE,
            IDX_C_FALL, IDX_C_RISE};
        msk = '{8'hfa, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h3f, 8'h3f};
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b0, idx[i], 8'h00);
            cmp(32'(d), 32'(REG_RESET));
            wb(1'b1, idx[i], 8'hff);
            wb(1'b0, idx[i], 8'h00);
            cmp(32'(d), 32'(msk[i]));
            wb(1'b1, idx[i], 8'h00);
        end
        sel_v = 4'h0;
        wb(1'b1, IDX_PRIO, 8'h0f);
        sel_v = 4'h1;
        wb(1'b0, IDX_PRIO, 8'h00);
        cmp(32'(d), 32'h0);
        wb(1'b1, 8'h80, 8'hff);
        wb(1'b0, 8'h80, 8'h00);
        cmp(32'(d), 32'h0);
        $display("regs done");
    endtask

    // Every pin, both edges, rise only, fall only and both
    task automatic t_edges();
        logic [7:0] ri [3];
        logic [7:0] fi [3];
        int w [3];
        ri = '{IDX_A_RISE, IDX_B_RISE, IDX_C_RISE};
        fi = '{IDX_A_FALL, IDX_B_FALL, IDX_C_FALL};
        w = '{A_PINS, B_PINS, C_PINS};
        for (int g = 0; g < 3; g++)
            for (int p = 0; p < w[g]; p++)
                for (int m = 0; m < 3; m++)
                begin
                    wb(1'b1, ri[g], (m != 1) ? 8'h01 << p : 8'h00);
                    wb(1'b1, fi[g], (m != 0) ? 8'h01 << p : 8'h00);
                    pin(g * 4 + p, 1'b1);
                    wb(1'b0, IDX_STAT, 8'h00);
                    cmp(32'(d[g]), 32'(m != 1));
                    wb(1'b1, IDX_STAT, 8'h07);
                    pin(g * 4 + p, 1'b0);
                    wb(1'b0, IDX_STAT, 8'h00);
                    cmp(32'(d[g]), 32'(m != 0));
                    wb(1'b1, IDX_STAT, 8'h07);
                end
        for (int g = 0; g < 3; g++)
        begin
            wb(1'b1, ri[g], 8'h00);
            wb(1'b1, fi[g], 8'h00);
        end
        wb(1'b1, IDX_TRC, 8'h00);
        $display("edges done");
    endtask

    // Sticky status, mask, level output
    task automatic t_irq();
        wb(1'b1, IDX_A_RISE, 8'h01);
        wb(1'b1, IDX_MASK, 8'h01);
        pin(0, 1'b1);
        cmp(32'(irq), 32'h1);
        wb(1'b1, IDX_MASK, 8'h02);
        cyc(2);
        cmp(32'(irq), 32'h0);
        wb(1'b1, IDX_MASK, 8'h01);
        cyc(2);
        cmp(32'(irq), 32'h1);
        wb(1'b1, IDX_STAT, 8'h01);
        cyc(2);
        cmp(32'(irq), 32'h0);
        pin(0, 1'b0);
        wb(1'b1, IDX_MASK, 8'h00);
        wb(1'b1, IDX_TRC, 8'h00);
        $display("irq done");
    endtask

    // Group flags, global enable, handshake with a slow core
    task automatic t_flags();
        core.log_q.delete();
        ab_prio <= 2'b10;
        wb(1'b1, IDX_CTRL, 8'h03);
        wb(1'b1, IDX_B_RISE, 8'h01);
        pin(0, 1'b1);
        wb(1'b0, IDX_TRC, 8'h00);
        cmp(32'(d), 32'h02);
        cyc(8);
        cmp(32'(req), 32'h0);
        wb(1'b1, IDX_CTRL, 8'h83);
        cyc(3);
        cmp({27'h0, req, high, vec}, {27'h0, 2'b10, SRC_A});
        pin(A_PINS, 1'b1);
        wb(1'b0, IDX_TRC, 8'h00);
        cmp(32'(d), 32'h0a);
        cmp({27'h0, req, high, vec}, {27'h0, 2'b11, SRC_B});
        ack_wait <= 4'h3;
        auto_en <= 1'b1;
        wait_log(2);
        cyc(10);
        wb(1'b0, IDX_TRC, 8'h00);
        cmp(32'(d), 32'h00);
        cmp(32'(core.log_q[0]), {26'h0, 3'b001, SRC_B});
        cmp(32'(core.log_q[1]), {26'h0, 3'b000, SRC_A});
        auto_en <= 1'b0;
        ack_wait <= 4'h0;
        ab_prio <= 2'b00;
        pin(0, 1'b0);
        pin(A_PINS, 1'b0);
        wb(1'b1, IDX_B_RISE, 8'h00);
        wb(1'b1, IDX_STAT, 8'h07);
        $display("flags done");
    endtask

    // Level bit per source, then equal-level query order
    task automatic t_prio();
        logic [2:0] src [4];
        src = '{SRC_SER, SRC_PWM, SRC_BT, SRC_C};
        core.log_q.delete();
        wb(1'b1, IDX_CTRL, 8'hbf);
        wb(1'b1, IDX_C_RISE, 8'h01);
        kick(3'h7);
        pin(8, 1'b1);
        cmp({27'h0, req, high, vec}, {27'h0, 2'b10, SRC_SER});
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, IDX_PRIO, 8'h01 << k);
            cyc(2);
            cmp({27'h0, req, high, vec}, {27'h0, 2'b11, src[k]});
        end
        wb(1'b1, IDX_PRIO, 8'h00);
        auto_en <= 1'b1;
        wait_log(4);
        cyc(20);
        cmp(32'(core.log_q.size()), 32'h4);
        for (int k = 0; k < 4; k++)
            cmp(32'(core.log_q[k]), {26'h0, 3'b000, src[k]});
        auto_en <= 1'b0;
        pin(8, 1'b0);
        $display("prio done");
    endtask

    // High nests over low; low waits out high, equal waits out equal
    task automatic t_nest();
        core.log_q.delete();
        svc_len <= 8'h28;
        wb(1'b1, IDX_PRIO, 8'h04);
        auto_en <= 1'b1;
        kick(3'h1);
        wait_log(1);
        kick(3'h4);
        wait_log(2);
        kick(3'h2);
        wait_log(3);
        cmp(32'(core.log_q[0]), {26'h0, 3'b000, SRC_SER});
        cmp(32'(core.log_q[1]), {26'h0, 3'b011, SRC_BT});
        cmp(32'(core.log_q[2]), {26'h0, 3'b000, SRC_PWM});
        auto_en <= 1'b0;
        svc_len <= 8'h04;
        $display("nest done");
    endtask

    // Main sequence, ends with a reset in mid-run
    initial
    begin
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_edges();
        t_irq();
        t_flags();
        t_prio();
        t_nest();
        sys_rst_i <= 1'b1;
        cyc(2);
        sys_rst_i <= 1'b0;
        wb(1'b0, IDX_PRIO, 8'h00);
        cmp(32'(d), 32'(REG_RESET));
        report_and_stop();
    end
endmodule
